// [src/sswd_top.sv]
`include "sswd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sswd_top
    import sswd_pkg::*;
#(
    parameter logic [`SSWD_CNT_W-1:0] RST_CYC  = `SSWD_CNT_W'(`SSWD_RST_CYC),
    parameter logic [`SSWD_CNT_W-1:0] WD_CYC   = `SSWD_CNT_W'(`SSWD_WD_CYC),
    parameter logic [`SSWD_CNT_W-1:0] IRQ_CYC  = `SSWD_CNT_W'(`SSWD_IRQ_CYC)
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // analog comparators and pins
    input  wire logic        supply_ok_i,
    input  wire logic        sense_ok_i,
    input  wire logic        processor_type_select_i,
    input  wire logic        watchdog_kick_i,
    input  wire logic        kick_present_i,
    // processor outputs
    output logic             reset_o,
    output logic             reset_n_o,
    output logic             power_fail_out_o,
    output logic             power_fail_out_n_o,
    output logic             early_power_irq_n_o,
    output logic             irq_o,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    // synchronisers
    logic [1:0] sup_s;
    logic [1:0] sen_s;
    logic [1:0] typ_s;
    logic [1:0] kick_s;
    logic [1:0] pres_s;
    logic       kick_d;
    always_ff @(posedge clk_i) begin
        sup_s  <= {sup_s[0], supply_ok_i};
        sen_s  <= {sen_s[0], sense_ok_i};
        typ_s  <= {typ_s[0], processor_type_select_i};
        kick_s <= {kick_s[0], watchdog_kick_i};
        pres_s <= {pres_s[0], kick_present_i};
        kick_d <= kick_s[1];
    end

    wire logic sup_ok    = sup_s[1];
    wire logic sen_ok    = sen_s[1];
    wire logic backed    = typ_s[1];
    wire logic kick_fall = kick_d & ~kick_s[1];

    sswd_state_t             state;
    sswd_state_t             next_state;
    logic [`SSWD_CNT_W-1:0]  cnt;
    logic [`SSWD_CNT_W-1:0]  next_cnt;
    logic [`SSWD_CNT_W-1:0]  irq_cnt;
    logic                    sup_d;
    logic                    powered;
    logic                    wd_en_sw;
    logic [`SSWD_EV_W-1:0]   status;
    logic [`SSWD_EV_W-1:0]   mask;

    wire logic wd_active = wd_en_sw & sup_ok & pres_s[1] & ~(backed & ~sen_ok);
    wire logic wd_expire = (state == SSWD_RUN) & wd_active & (cnt >= WD_CYC - 1'b1);
    wire logic sup_fall  = sup_d & ~sup_ok;
    wire logic sup_rise  = ~sup_d & sup_ok;
    wire logic irq_trig  = backed & ((sup_fall & sen_ok)
                           | (~sen_ok & sup_ok & (kick_fall | sup_rise)));
    // supply loss resets only in non-backed style, or before first power-up
    wire logic sup_hold  = ~sup_ok & (~backed | ~powered);
    wire logic rst_on    = (state != SSWD_RUN);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            SSWD_RUN: begin
                if (sup_hold) begin
                    next_state = SSWD_HOLD;
                    next_cnt   = '0;
                end else if (backed & sup_rise) begin
                    next_state = SSWD_STRETCH;
                    next_cnt   = '0;
                end else if (wd_expire) begin
                    next_state = SSWD_STRETCH;
                    next_cnt   = '0;
                end else if (kick_fall | ~wd_active) begin
                    next_cnt   = '0;
                end else begin
                    next_cnt   = cnt + 1'b1;
                end
            end
            SSWD_HOLD: begin
                next_cnt = '0;
                if (sup_ok) begin
                    next_state = SSWD_STRETCH;
                end
            end
            SSWD_STRETCH: begin
                if (sup_hold) begin
                    next_state = SSWD_HOLD;
                    next_cnt   = '0;
                end else if (cnt >= RST_CYC - 1'b1) begin
                    next_state = SSWD_RUN;
                    next_cnt   = '0;
                end else begin
                    next_cnt   = cnt + 1'b1;
                end
            end
            default: begin
                next_state = SSWD_HOLD;
                next_cnt   = '0;
            end
        endcase
    end

    // register bus decode
    wire logic       wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic       wb_wr      = wb_req & wb_we_i & wb_sel_i[0];

    // address match per register
    wire logic       sel_status = (wb_adr_i == `SSWD_ADR_STATUS);
    wire logic       sel_mask   = (wb_adr_i == `SSWD_ADR_MASK);
    wire logic       sel_state  = (wb_adr_i == `SSWD_ADR_STATE);
    wire logic       sel_ctrl   = (wb_adr_i == `SSWD_ADR_CTRL);

    // write strobes, taken on the request edge
    wire logic       wr_stat    = wb_wr & sel_status;
    wire logic       wr_mask    = wb_wr & sel_mask;
    wire logic       wr_ctrl    = wb_wr & sel_ctrl;

    // event sources, one sticky bit each
    wire logic [`SSWD_EV_W-1:0] ev;
    assign ev[`SSWD_EV_PFAIL] = sup_fall;
    assign ev[`SSWD_EV_WDOG]  = wd_expire;
    assign ev[`SSWD_EV_IRQ]   = irq_trig;

    // write one to clear; a new event wins over the clear
    wire logic [`SSWD_EV_W-1:0] clr         = wr_stat ? wb_dat_i[`SSWD_EV_W-1:0] : '0;
    wire logic [`SSWD_EV_W-1:0] next_status = (status & ~clr) | ev;
    wire logic [`SSWD_EV_W-1:0] next_mask   = wr_mask ? wb_dat_i[`SSWD_EV_W-1:0] : mask;
    wire logic                  next_wd_en  = wr_ctrl ? wb_dat_i[0] : wd_en_sw;

    // read words
    wire logic [31:0] rd_status = {29'h0000_0000, status};
    wire logic [31:0] rd_maskw  = {29'h0000_0000, mask};
    wire logic [31:0] rd_state  = {26'h000_0000, state, sen_ok, sup_ok, backed, wd_active};
    wire logic [31:0] rd_ctrl   = {31'h0000_0000, wd_en_sw};

    // unmapped addresses read zero
    wire logic [31:0] rd_mux =
        sel_status ? rd_status :
        sel_mask   ? rd_maskw  :
        sel_state  ? rd_state  :
        sel_ctrl   ? rd_ctrl   : 32'h0000_0000;

    // data only while acking
    wire logic [31:0] next_dat = wb_req ? rd_mux : 32'h0000_0000;

    wire logic [`SSWD_CNT_W-1:0] irq_load = IRQ_CYC - 1'b1;
    wire logic                   irq_busy = (irq_cnt != '0);
    wire logic                   next_irq_n = ~(irq_trig | irq_busy);
    wire logic                   next_irq   = |(next_status & mask);

    // output pair values, one step ahead of the flops
    sswd_out_t next_out;
    assign next_out = '{
        rst:   (next_state != SSWD_RUN),
        rst_n: (next_state == SSWD_RUN),
        pf:    ~sup_ok,
        pf_n:  sup_ok
    };

    // supervisor state and shared interval counter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= SSWD_HOLD;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // supply edge history
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sup_d <= 1'b0;
        end else begin
            sup_d <= sup_ok;
        end
    end

    // first power-up completed
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            powered <= 1'b0;
        end else if (sup_ok & ~rst_on) begin
            powered <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_cnt <= '0;
        end else if (irq_trig) begin
            irq_cnt <= irq_load;
        end else if (irq_busy) begin
            irq_cnt <= irq_cnt - 1'b1;
        end
    end

    // sticky event status
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mask <= '0;
        end else begin
            mask <= next_mask;
        end
    end

    // software watchdog enable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wd_en_sw <= 1'b1;
        end else begin
            wd_en_sw <= next_wd_en;
        end
    end

    // single-cycle acknowledge
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // read data register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= next_dat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reset_o   <= 1'b1;
            reset_n_o <= 1'b0;
        end else begin
            reset_o   <= next_out.rst;
            reset_n_o <= next_out.rst_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            power_fail_out_o   <= 1'b1;
            power_fail_out_n_o <= 1'b0;
        end else begin
            power_fail_out_o   <= next_out.pf;
            power_fail_out_n_o <= next_out.pf_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            early_power_irq_n_o <= 1'b1;
        end else begin
            early_power_irq_n_o <= next_irq_n;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end
endmodule // sswd_top
`default_nettype wire

// [common/sswd_cfg.svh]
`ifndef SSWD_CFG_SVH
`define SSWD_CFG_SVH
// clock rate in kHz
`define SSWD_CLK_KHZ        125000
// power-on and watchdog reset stretch, least time in ms
`define SSWD_RST_MS         25
// watchdog timeout, longest time 600 ms, typical 400 ms
`define SSWD_WD_MS          400
// early warning pulse, least time in us
`define SSWD_IRQ_US         200
`define SSWD_RST_CYC        (`SSWD_RST_MS * `SSWD_CLK_KHZ)
`define SSWD_WD_CYC         (`SSWD_WD_MS * `SSWD_CLK_KHZ)
`define SSWD_IRQ_CYC        ((`SSWD_IRQ_US * `SSWD_CLK_KHZ + 999) / 1000)
// kick floating: unused idle-cycle count; an open kick is flagged by kick_present_i
`define SSWD_OPEN_CYC       32'h0000_0000
`define SSWD_CNT_W          32
// wishbone register byte addresses
`define SSWD_ADR_STATUS     8'h00
`define SSWD_ADR_MASK       8'h04
`define SSWD_ADR_STATE      8'h08
`define SSWD_ADR_CTRL       8'h0C
// status and mask bit positions
`define SSWD_EV_PFAIL       0
`define SSWD_EV_WDOG        1
`define SSWD_EV_IRQ         2
`define SSWD_EV_W           3
`endif

// [common/sswd_pkg.sv]
package sswd_pkg;
    typedef enum logic [1:0] {
        SSWD_RUN,
        SSWD_HOLD,
        SSWD_STRETCH
    } sswd_state_t;

    typedef struct packed {
        logic rst;
        logic rst_n;
        logic pf;
        logic pf_n;
    } sswd_out_t;
endpackage

// [verif/sswd_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module sswd_properties #(
    parameter logic [31:0] RST_CYC = 32'h0000_0014,
    parameter logic [31:0] WD_CYC  = 32'h0000_0032
) (
    input wire logic        clk_i, sys_rst_i, supply_ok_i, processor_type_select_i,
    input wire logic        watchdog_kick_i, kick_present_i, reset_o, reset_n_o, irq_o,
    input wire logic        power_fail_out_o, power_fail_out_n_o, early_power_irq_n_o,
    input wire logic        wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic [31:0] wb_dat_o
);
    logic [31:0] hi_cnt, lo_cnt;
    logic        kick_q;
    // watchdog counted only where it must run
    wire wd_off = reset_o || !kick_present_i || processor_type_select_i || !supply_ok_i;
    wire kick_fall = kick_q && !watchdog_kick_i;
    always_ff @(posedge clk_i) begin
        kick_q <= watchdog_kick_i;
        hi_cnt <= (sys_rst_i || !reset_o) ? '0 : hi_cnt + 1;
        lo_cnt <= (sys_rst_i || wd_off || kick_fall) ? '0 : lo_cnt + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_rst_pair: assert property (reset_n_o == !reset_o)
        else $error("reset pair differs");
    a_pf_pair: assert property (power_fail_out_n_o == !power_fail_out_o)
        else $error("power fail pair differs");
    a_supply_low: assert property ((!supply_ok_i && !processor_type_select_i)[*5] |-> reset_o && power_fail_out_o)
        else $error("supply low without reset");
    a_pf_clear: assert property (supply_ok_i[*5] |-> !power_fail_out_o)
        else $error("power fail while supply good");
    a_rst_stretch: assert property ($fell(reset_o) |-> hi_cnt >= RST_CYC)
        else $error("reset released too early");
    a_wd_early: assert property ($rose(reset_o) && !processor_type_select_i && supply_ok_i
        && $past(supply_ok_i, 6) |-> lo_cnt >= WD_CYC - 2)
        else $error("watchdog expired early");
    a_wd_late: assert property (lo_cnt <= WD_CYC + 6)
        else $error("watchdog did not expire");
    // irq width 5 matches the bench IRQ_CYC
    a_irq_width: assert property ($fell(early_power_irq_n_o) |-> !early_power_irq_n_o[*5])
        else $error("early irq pulse too short");
    a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack wrong");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");
    c_wd: cover property ($rose(reset_o) && supply_ok_i);
    c_irq: cover property ($fell(early_power_irq_n_o));
    c_int: cover property ($rose(irq_o));
endmodule // sswd_properties
bind sswd_top sswd_properties #(.RST_CYC(RST_CYC), .WD_CYC(WD_CYC)) u_props (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i), .irq_o(irq_o),
    .processor_type_select_i(processor_type_select_i), .watchdog_kick_i(watchdog_kick_i),
    .kick_present_i(kick_present_i), .reset_o(reset_o), .reset_n_o(reset_n_o),
    .power_fail_out_o(power_fail_out_o), .power_fail_out_n_o(power_fail_out_n_o),
    .early_power_irq_n_o(early_power_irq_n_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
`default_nettype wire

// [verif/sswd_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sswd_cpu_model #(
    parameter int PERIOD = 30
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic kick_en_i,
    output logic      kick_o
);
    int cnt = 0;
    always_ff @(posedge clk_i) begin
        cnt <= (!reset_n_i || !kick_en_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    assign kick_o = !(cnt == PERIOD - 1);
endmodule // sswd_cpu_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sswd_cfg.svh"
module testbench;
    logic        clk = 0, rst = 1, sup = 1, sen = 1, typ = 0, kpres = 1, ken = 1;
    logic        cyc = 0, stb = 0, we = 0, kick, seen;
    logic        rs, rs_n, pf, pf_n, irq_n, irq, ack;
    logic [7:0]  adr = '0;
    logic [31:0] dat = '0, rdat, q;
    int          fail_count = 0, n_tests = 0, n;
    initial forever #4 clk = !clk;
    sswd_top #(.RST_CYC(32'h0000_0014), .WD_CYC(32'h0000_0032), .IRQ_CYC(32'h0000_0005)) dut (
        .clk_i(clk), .sys_rst_i(rst), .supply_ok_i(sup), .sense_ok_i(sen),
        .processor_type_select_i(typ), .watchdog_kick_i(kick), .kick_present_i(kpres),
        .reset_o(rs), .reset_n_o(rs_n), .power_fail_out_o(pf), .power_fail_out_n_o(pf_n),
        .early_power_irq_n_o(irq_n), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack));
    sswd_cpu_model #(.PERIOD(30)) cpu (.clk_i(clk), .reset_n_i(rs_n), .kick_en_i(ken),
        .kick_o(kick));
    task summarize;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        i = 0;
        do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (i >= 20) begin fail_count++; summarize(); end
    endtask
    // cycles until reset output reaches v, left in n
    task wait_rs(input logic v);
        n = 0;
        do begin @(posedge clk); n++; end while (rs !== v && n < 400);
        if (n >= 400) begin fail_count++; summarize(); end
    endtask
    task watch(input int c);
        seen = 0;
        repeat (c) begin @(posedge clk); if (irq_n === 1'b0) seen = 1; end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        wait_rs(0); chk(n >= 20, 1);
        chk({pf, pf_n}, 2'b01);
        $display("power-up test done");
        repeat (200) @(posedge clk);
        chk(rs, 0);
        wb(0, `SSWD_ADR_STATE, 0); chk(q, 32'h0000_000D);
        wb(0, `SSWD_ADR_CTRL, 0); chk(q, 32'h0000_0001);
        wb(1, `SSWD_ADR_CTRL, 0); wb(0, `SSWD_ADR_STATE, 0); chk(q, 32'h0000_000C);
        wb(1, `SSWD_ADR_CTRL, 32'h0000_0001); wb(0, `SSWD_ADR_CTRL, 0); chk(q, 32'h0000_0001);
        sen <= 0; ken <= 0;
        wait_rs(1); chk(n <= 60, 1);
        wait_rs(0); chk(n >= 20, 1);
        ken <= 1; sen <= 1;
        wb(0, `SSWD_ADR_STATUS, 0); chk(q[`SSWD_EV_WDOG], 1);
        chk(irq, 0);
        wb(1, `SSWD_ADR_MASK, 32'h0000_0002); repeat (2) @(posedge clk); chk(irq, 1);
        wb(1, `SSWD_ADR_STATUS, 32'h0000_0002); repeat (2) @(posedge clk); chk(irq, 0);
        wb(0, 8'h10, 0); chk(q, 0);
        $display("watchdog test done");
        sup <= 0; repeat (8) @(posedge clk); chk({rs, rs_n, pf, pf_n}, 4'b1010);
        repeat (40) @(posedge clk); chk(rs, 1);
        sup <= 1; wait_rs(0); chk(n >= 20, 1);
        typ <= 1; repeat (20) @(posedge clk);
        sup <= 0; ken <= 0; watch(12); chk(seen, 1);
        repeat (100) @(posedge clk); chk({rs, pf}, 2'b01);
        sup <= 1; sen <= 0; wait_rs(1); wait_rs(0); chk(n >= 20, 1);
        repeat (150) @(posedge clk); chk(rs, 0);
        ken <= 1; watch(40); chk(seen, 1);
        $display("backed test done");
        typ <= 0; sen <= 1; kpres <= 0; ken <= 0;
        repeat (150) @(posedge clk); chk(rs, 0);
        $display("kick open test done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
